//--- rtl/trb_pkg.sv
package trb_pkg;
    // ----------------------------------------------------------------
    // bus widths and fields
    // ----------------------------------------------------------------
    localparam int TBUS_W = 40;
    localparam int TAG_W = 20;
    localparam int IDX_W = 11;
    localparam int FN_W = 4;
    localparam int IDX_LSB = 9;
    localparam int TAG_LSB = 20;
    localparam logic [3:0] FN_IDLE = 4'h0;
    localparam logic [3:0] FN_EVEN_RD = 4'h5;
    localparam logic [3:0] FN_ODD_RD = 4'h6;
    localparam logic [3:0] FN_STATE_WR = 4'h9;
    // state write word layout on the tag bus
    localparam int WR_DIRTY_BIT = 39;
    localparam int WR_SYN_EN_BIT = 38;
    localparam int WR_SEC_EN_LSB = 34;
    localparam int SYN_LSB = 30;
    localparam int STATE_LSB = 22;
    // ----------------------------------------------------------------
    // pipeline stage positions
    // ----------------------------------------------------------------
    localparam int DEV_PIPE = 6;
    localparam int DEV_PIN_STG = 1;
    localparam int DEV_SMP_STG = 3;
    localparam int DEV_EARLY_STG = 4;
    localparam int DEV_RET_STG = 5;
    localparam int CC_PIPE = 7;
    localparam int CC_STATE_READ_SELECT_STG = 1;
    localparam int CC_SET_STG = 2;
    localparam int CC_WE_STG = 2;
    localparam int CC_OE_STG = 3;
    localparam int CC_DROP_STG = 6;
    // ----------------------------------------------------------------
    // controller register map and fields
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_WDATA = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RD_LO = 8'h0C;
    localparam logic [7:0] REG_RD_HI = 8'h10;
    localparam int CMD_SET_LSB = 11;
    localparam int CMD_KIND_LSB = 13;
    localparam int CMD_ODD_BIT = 15;
    localparam int CMD_DIRTY2_BIT = 16;
    localparam int WD_DIRTY = 0;
    localparam int WD_SYN_EN = 1;
    localparam int WD_SEC_EN_LSB = 2;
    localparam int WD_SYN_LSB = 6;
    localparam int WD_STATE_LSB = 10;
    localparam int WD_W = 18;
    localparam int ST_READY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_BUS_LSB = 3;

    typedef enum logic [1:0] {TRB_TAG_RD, TRB_STATE_RD, TRB_STATE_WR, TRB_KIND_RSV} trb_kind_t;
    typedef enum logic [1:0] {TRB_CC_OWN, TRB_RELEASE, TRB_CPU_OWN, TRB_TURNAROUND} trb_bus_t;

    // tag bus 39:22 to tag ram 17:0, tag bus 21:20 to tag ram 19:18
    function automatic logic [19:0] tbus_to_tram(input logic [39:0] b);
        return {b[21:20], b[39:22]};
    endfunction

    function automatic logic [39:0] tram_to_tbus(input logic [19:0] t);
        return {t[17:0], t[19:18], 20'h00000};
    endfunction
endpackage

//--- rtl/trb_if.sv
`timescale 1ns/1ps
interface trb_if;
    logic [trb_pkg::TBUS_W-1:0] tbus_cc;
    logic tbus_cc_oe;
    logic [trb_pkg::FN_W-1:0] func;
    logic [trb_pkg::TBUS_W-1:0] tbus_cpu;
    logic tbus_cpu_oe;
    logic controller_bus_request_n;
    logic cpu_bus_release_n;
    logic [1:0] set_select_lines;
    logic state_read_select_n;
    logic tag_write_strobe_n;
    logic state_write_strobe_n;
    logic tram_oe_n;

    modport cc (
        output tbus_cc, tbus_cc_oe, func, controller_bus_request_n,
        output set_select_lines, state_read_select_n, tag_write_strobe_n,
        output state_write_strobe_n, tram_oe_n,
        input tbus_cpu, tbus_cpu_oe, cpu_bus_release_n
    );
    modport cpu (
        input tbus_cc, tbus_cc_oe, func, controller_bus_request_n,
        output tbus_cpu, tbus_cpu_oe, cpu_bus_release_n
    );
endinterface

//--- rtl/trb_cpu_end.sv
`timescale 1ns/1ps
module trb_cpu_end (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    trb_if.cpu bus,
    output logic [10:0] tram_index,
    output logic tram_odd_sel,
    output logic [19:0] tram_tag_out,
    output logic tram_tag_oe,
    input wire logic [19:0] tram_tag_in
);
    // ----------------------------------------------------------------
    // operation pipeline, entry k is k+2 clocks after issue
    // ----------------------------------------------------------------
    logic [trb_pkg::DEV_PIPE-1:0] p_v, p_rd, p_wr, p_odd, p_e;
    logic [10:0] p_idx [trb_pkg::DEV_PIPE];
    logic [39:0] p_dat [trb_pkg::DEV_PIPE];
    logic [39:0] tbus_q;
    logic drv_q;
    logic rel_q;

    // function decode
    wire fn_even = bus.func == trb_pkg::FN_EVEN_RD;
    wire fn_odd = bus.func == trb_pkg::FN_ODD_RD;
    wire fn_wr = bus.func == trb_pkg::FN_STATE_WR;
    wire a_rd = bus.tbus_cc_oe && (fn_even || fn_odd);
    wire a_wr = bus.tbus_cc_oe && fn_wr;
    wire [10:0] a_idx = bus.tbus_cc[trb_pkg::IDX_LSB +: trb_pkg::IDX_W];
    // same read twice in a row: dirty access, time from the second copy
    wire rep = a_rd && p_v[0] && p_rd[0] && p_idx[0] == a_idx && p_odd[0] == fn_odd;
    // return slots
    wire e_rd = p_v[trb_pkg::DEV_EARLY_STG] && p_rd[trb_pkg::DEV_EARLY_STG];
    wire ld_early = e_rd && p_v[trb_pkg::DEV_SMP_STG] && p_rd[trb_pkg::DEV_SMP_STG];
    wire ld_norm = p_v[trb_pkg::DEV_RET_STG] && p_rd[trb_pkg::DEV_RET_STG]
        && !p_e[trb_pkg::DEV_RET_STG];
    wire ld = ld_early || ld_norm;
    wire pend = e_rd || ld_norm;
    wire rel_d = drv_q && !ld && !pend;
    wire [19:0] ret_tag = ld_early ? p_dat[trb_pkg::DEV_EARLY_STG][19:0]
        : p_dat[trb_pkg::DEV_RET_STG][19:0];

    // ----------------------------------------------------------------
    // control flags
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            p_v <= '0;
            drv_q <= 1'b0;
            rel_q <= 1'b0;
        end else if (ce) begin
            p_v <= {p_v[trb_pkg::DEV_PIPE-2:1], p_v[0] && !rep, a_rd || a_wr};
            drv_q <= ld;
            rel_q <= rel_d;
        end
    end

    // per-entry fields, shifted along with the flags
    always_ff @(posedge mclk) begin
        if (ce) begin
            p_rd <= {p_rd[trb_pkg::DEV_PIPE-2:0], a_rd};
            p_wr <= {p_wr[trb_pkg::DEV_PIPE-2:0], a_wr};
            p_odd <= {p_odd[trb_pkg::DEV_PIPE-2:0], fn_odd};
            p_e <= {ld_early, p_e[trb_pkg::DEV_RET_STG-2:0], 1'b0};
            p_idx[0] <= a_idx;
            p_dat[0] <= a_wr ? bus.tbus_cc : 40'h00000_00000;
            for (int k = 1; k < trb_pkg::DEV_PIPE; k++) begin
                p_idx[k] <= p_idx[k-1];
                p_dat[k] <= p_dat[k-1];
            end
            // tag ram answer: tag word or one set's states and synonym
            if (p_rd[trb_pkg::DEV_SMP_STG]) begin
                p_dat[trb_pkg::DEV_SMP_STG+1] <= {20'h00000, tram_tag_in};
            end
        end
    end

    // returned word, all forty bits driven
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tbus_q <= 40'h00000_00000;
        end else if (ce && ld) begin
            tbus_q <= trb_pkg::tram_to_tbus(ret_tag);
        end
    end

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    // drive only while the controller has let go of the bus
    assign bus.tbus_cpu = tbus_q;
    assign bus.tbus_cpu_oe = drv_q && bus.controller_bus_request_n;
    assign bus.cpu_bus_release_n = !rel_q;
    // index reaches the tag ram three clocks after issue
    assign tram_index = p_idx[trb_pkg::DEV_PIN_STG];
    assign tram_odd_sel = p_odd[trb_pkg::DEV_PIN_STG];
    assign tram_tag_out = trb_pkg::tbus_to_tram(p_dat[trb_pkg::DEV_PIN_STG]);
    // tag pins float for reads so the ram can answer
    assign tram_tag_oe = p_v[trb_pkg::DEV_PIN_STG] && p_wr[trb_pkg::DEV_PIN_STG];
endmodule

//--- rtl/trb_cc_end.sv
`timescale 1ns/1ps
// What this block does
// - code 6h means odd tag ram read
// - controller alone picks tag or state read
// - index clock 1, set select clock 3
// - tag read keeps state-read select off
// - ram output enable clock 4, data clock 5
// - cpu returns tag data in clock 8
// - controller drops request clock 7, bus floats
// - cpu owns and drives bus clock 8
// - cpu release clock 9, turnaround, controller again
// - new operation needs an idle pipeline, except a tag read one clock after a lone tag read
// - back-to-back reads return clocks 7, 9
// - state write: state strobe, tag strobe off
// - write bits 39..34: dirty, synonym, sector enables
// - write bits 33:30 synonym, states, index 19:9
// - ram line four sets; one set returned
// - no leaving controller ownership during state write
// - dirty read: index driven two clocks
// - state read: select clock 3, set clock 4
// - cpu floats tag pins; enable clock 5, data 6
// - state data clock 9, release clock 10
// - twenty bits in, forty bits returned
// - state return layout: dirty, synonym, sector states
// - code 5h means even tag ram read
module trb_cc_end (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    trb_if.cc bus,
    input wire logic [trb_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [trb_pkg::CC_PIPE-1:0] cp_v, cp_lead;
    trb_pkg::trb_kind_t cp_kind [trb_pkg::CC_PIPE];
    logic [1:0] cp_set [trb_pkg::CC_PIPE];
    logic [39:0] bus_q;
    logic [3:0] func_q;
    logic rep_q;
    logic [trb_pkg::WD_W-1:0] wd_q;
    logic [39:0] cap_q;
    logic done_q;
    logic refused_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;
    trb_pkg::trb_bus_t st_q, st_d;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // live read at a pipeline stage, lead copy of a dirty read excluded
    function automatic logic is_rd(input logic v, input logic lead,
            input trb_pkg::trb_kind_t kind);
        return v && !lead && kind != trb_pkg::TRB_STATE_WR;
    endfunction

    // live read flags by stage, re-evaluated whenever the pipeline moves
    logic [trb_pkg::CC_PIPE-1:0] live_rd;
    always_comb begin
        for (int k = 0; k < trb_pkg::CC_PIPE; k++) begin
            live_rd[k] = is_rd(cp_v[k], cp_lead[k], cp_kind[k]);
        end
    end

    // state write word from the write-data register
    function automatic logic [39:0] build_wr(input logic [trb_pkg::WD_W-1:0] w,
            input logic [10:0] idx);
        logic [39:0] b;
        b = 40'h00000_00000;
        b[trb_pkg::WR_DIRTY_BIT] = w[trb_pkg::WD_DIRTY];
        b[trb_pkg::WR_SYN_EN_BIT] = w[trb_pkg::WD_SYN_EN];
        b[trb_pkg::WR_SEC_EN_LSB +: 4] = w[trb_pkg::WD_SEC_EN_LSB +: 4];
        b[trb_pkg::SYN_LSB +: 4] = w[trb_pkg::WD_SYN_LSB +: 4];
        b[trb_pkg::STATE_LSB +: 8] = w[trb_pkg::WD_STATE_LSB +: 8];
        b[trb_pkg::IDX_LSB +: trb_pkg::IDX_W] = idx;
        return b;
    endfunction

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    wire sel_cmd = addr == trb_pkg::REG_CMD;
    wire sel_wd = addr == trb_pkg::REG_WDATA;
    wire sel_st = addr == trb_pkg::REG_STATUS;
    wire sel_lo = addr == trb_pkg::REG_RD_LO;
    wire sel_hi = addr == trb_pkg::REG_RD_HI;
    wire [10:0] c_idx = wdata[trb_pkg::IDX_W-1:0];
    wire [1:0] c_set = wdata[trb_pkg::CMD_SET_LSB +: 2];
    wire [1:0] c_kind_raw = wdata[trb_pkg::CMD_KIND_LSB +: 2];
    trb_pkg::trb_kind_t c_kind;
    assign c_kind = trb_pkg::trb_kind_t'(c_kind_raw);
    wire c_odd = wdata[trb_pkg::CMD_ODD_BIT];
    wire c_dirty2 = wdata[trb_pkg::CMD_DIRTY2_BIT];

    // ----------------------------------------------------------------
    // acceptance and bus hand-off
    // ----------------------------------------------------------------
    // request dropped the clock before the cpu returns data
    wire drop = live_rd[trb_pkg::CC_DROP_STG]
        || (live_rd[trb_pkg::CC_DROP_STG-1] && live_rd[trb_pkg::CC_DROP_STG-2]);
    wire own = st_q == trb_pkg::TRB_CC_OWN && !drop;
    // a second tag read may follow a lone tag read one clock later
    wire pair_ok = cp_v == 7'h01 && cp_kind[0] == trb_pkg::TRB_TAG_RD && !cp_lead[0]
        && c_kind == trb_pkg::TRB_TAG_RD;
    // state reads and writes need an idle pipeline, nothing may cut in
    wire ready = own && !rep_q && (cp_v == 7'h00 || pair_ok);
    wire cmd_wr = wr && sel_cmd;
    wire launch = cmd_wr && c_kind != trb_pkg::TRB_KIND_RSV && ready;
    wire refuse = cmd_wr && !launch;
    wire [3:0] c_func = c_kind == trb_pkg::TRB_STATE_WR ? trb_pkg::FN_STATE_WR
        : c_odd ? trb_pkg::FN_ODD_RD : trb_pkg::FN_EVEN_RD;
    wire [39:0] c_word = c_kind == trb_pkg::TRB_STATE_WR ? build_wr(wd_q, c_idx)
        : {20'h00000, c_idx, 9'h000};

    // bus ownership sequence
    always_comb begin
        st_d = st_q;
        case (st_q)
            trb_pkg::TRB_CC_OWN: begin
                if (drop) begin
                    st_d = trb_pkg::TRB_RELEASE;
                end
            end
            trb_pkg::TRB_RELEASE: begin
                st_d = trb_pkg::TRB_CPU_OWN;
            end
            trb_pkg::TRB_CPU_OWN: begin
                if (!bus.cpu_bus_release_n) begin
                    st_d = trb_pkg::TRB_TURNAROUND;
                end
            end
            trb_pkg::TRB_TURNAROUND: begin
                st_d = trb_pkg::TRB_CC_OWN;
            end
            default: begin
                st_d = trb_pkg::TRB_CC_OWN;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // operation pipeline, entry k is k+1 clocks after issue
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cp_v <= '0;
            cp_lead <= '0;
            rep_q <= 1'b0;
            st_q <= trb_pkg::TRB_CC_OWN;
        end else if (ce) begin
            cp_v <= {cp_v[trb_pkg::CC_PIPE-2:0], launch || rep_q};
            cp_lead <= {cp_lead[trb_pkg::CC_PIPE-2:0], launch && c_dirty2};
            // dirty state read repeats its index one more clock
            rep_q <= launch && c_kind == trb_pkg::TRB_STATE_RD && c_dirty2;
            st_q <= st_d;
        end
    end

    // entry fields; a repeat keeps stage 0 as it is
    always_ff @(posedge mclk) begin
        if (ce) begin
            cp_kind[0] <= launch ? c_kind : cp_kind[0];
            cp_set[0] <= launch ? c_set : cp_set[0];
            for (int k = 1; k < trb_pkg::CC_PIPE; k++) begin
                cp_kind[k] <= cp_kind[k-1];
                cp_set[k] <= cp_set[k-1];
            end
            if (launch) begin
                bus_q <= c_word;
                func_q <= c_func;
            end
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wd_q <= '0;
            done_q <= 1'b0;
            refused_q <= 1'b0;
            cap_q <= 40'h00000_00000;
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            if (wr && sel_wd) begin
                wd_q <= wdata[trb_pkg::WD_W-1:0];
            end
            if (bus.tbus_cpu_oe) begin
                cap_q <= bus.tbus_cpu;
            end
            // a new event wins over the clear-on-read
            done_q <= bus.tbus_cpu_oe || (done_q && !(rd && sel_st));
            refused_q <= refuse || (refused_q && !(rd && sel_st));
            rdata_q <= rd ? rd_mux : 32'h0000_0000;
        end
    end

    // read selection, unmapped addresses read zero
    assign rd_mux = sel_wd ? {14'h0000, wd_q}
        : sel_st ? {27'h0000000, st_q, refused_q, done_q, ready}
        : sel_lo ? cap_q[31:0]
        : sel_hi ? {24'h000000, cap_q[39:32]}
        : 32'h0000_0000;
    assign rdata = rdata_q;

    // ----------------------------------------------------------------
    // tag bus and hard-wired tag ram controls
    // ----------------------------------------------------------------
    assign bus.tbus_cc = cp_v[0] ? bus_q : 40'h00000_00000;
    assign bus.func = cp_v[0] ? func_q : trb_pkg::FN_IDLE;
    assign bus.tbus_cc_oe = own;
    assign bus.controller_bus_request_n = !own;
    // set select two clocks after the index of the timed copy
    assign bus.set_select_lines = cp_v[trb_pkg::CC_SET_STG] && !cp_lead[trb_pkg::CC_SET_STG]
        ? cp_set[trb_pkg::CC_SET_STG] : 2'h0;
    // state read select low only for state reads
    assign bus.state_read_select_n = !(live_rd[trb_pkg::CC_STATE_READ_SELECT_STG]
        && cp_kind[trb_pkg::CC_STATE_READ_SELECT_STG] == trb_pkg::TRB_STATE_RD);
    // ram output enable, data follows one clock later
    assign bus.tram_oe_n = !live_rd[trb_pkg::CC_OE_STG];
    // only state writes issue here, the tag strobe stays off
    assign bus.tag_write_strobe_n = 1'b1;
    assign bus.state_write_strobe_n = !(cp_v[trb_pkg::CC_WE_STG]
        && cp_kind[trb_pkg::CC_WE_STG] == trb_pkg::TRB_STATE_WR);
endmodule

//--- tb/trb_chk.sv
`timescale 1ns/1ps
module trb_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic tbus_cc_oe,
    input wire logic [trb_pkg::FN_W-1:0] func,
    input wire logic [trb_pkg::TBUS_W-1:0] tbus_cpu,
    input wire logic tbus_cpu_oe,
    input wire logic controller_bus_request_n,
    input wire logic cpu_bus_release_n,
    input wire logic state_read_select_n,
    input wire logic tag_write_strobe_n,
    input wire logic state_write_strobe_n,
    input wire logic tram_oe_n
);
    // ----------------------------------------------------------------
    // decoded controller codes
    // ----------------------------------------------------------------
    wire logic rd_code;
    wire logic wr_code;
    assign rd_code = tbus_cc_oe && (func == trb_pkg::FN_EVEN_RD || func == trb_pkg::FN_ODD_RD);
    assign wr_code = tbus_cc_oe && (func == trb_pkg::FN_STATE_WR);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // link timing
    // ----------------------------------------------------------------
    a_code_to_oe: assert property (
        rd_code ##1 !rd_code |-> ##2 !tram_oe_n) else $error("ram enable late");
    a_code_to_ret: assert property (
        rd_code ##1 !rd_code |-> ##6 tbus_cpu_oe) else $error("return clock wrong");
    a_state_read_select_to_oe: assert property (
        !state_read_select_n |-> ##2 !tram_oe_n) else $error("state select not before enable");
    a_write_strobes: assert property (
        wr_code |-> ##2 (!state_write_strobe_n && tag_write_strobe_n))
        else $error("state write strobes wrong");
    a_req_to_ret: assert property (
        $rose(controller_bus_request_n) |-> !tbus_cc_oe ##1 tbus_cpu_oe)
        else $error("no return after request drop");
    a_req_float: assert property (
        controller_bus_request_n |-> !tbus_cc_oe) else $error("controller drives without request");
    a_cpu_excl: assert property (
        tbus_cpu_oe |-> (!tbus_cc_oe && controller_bus_request_n)) else $error("bus contention");
    a_release_ret: assert property (
        $fell(cpu_bus_release_n) |-> ($past(tbus_cpu_oe) && !tbus_cc_oe))
        else $error("release not after return");
    a_release_back: assert property (
        $fell(cpu_bus_release_n) |-> ##2 (tbus_cc_oe && !controller_bus_request_n))
        else $error("controller not back after turnaround");
    a_ret_low_zero: assert property (
        tbus_cpu_oe |-> tbus_cpu[19:0] == 20'h00000) else $error("return low bits not zero");
endmodule

//--- tb/tag_ram_bus_access_cycles_tb_top.sv
`timescale 1ns/1ps
module tag_ram_bus_access_cycles_tb_top;
    logic mclk;
    logic rst_n;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic [10:0] tram_index;
    logic tram_odd_sel;
    logic [19:0] tram_tag_out;
    logic tram_tag_oe;
    logic [19:0] tram_tag_in;
    logic [10:0] idx_q;
    logic [1:0] set_q;
    int bad_count;
    int compares;
    int cyc = 0;

    trb_if bus_if ();
    trb_cc_end i_trb_cc_end (.mclk(mclk), .rst_n(rst_n), .ce(1'h1), .bus(bus_if.cc),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    trb_cpu_end i_trb_cpu_end (.mclk(mclk), .rst_n(rst_n), .ce(1'h1), .bus(bus_if.cpu),
        .tram_index(tram_index), .tram_odd_sel(tram_odd_sel), .tram_tag_out(tram_tag_out),
        .tram_tag_oe(tram_tag_oe), .tram_tag_in(tram_tag_in));
    trb_chk i_trb_chk (.mclk(mclk), .rst_n(rst_n), .tbus_cc_oe(bus_if.tbus_cc_oe),
        .func(bus_if.func), .tbus_cpu(bus_if.tbus_cpu), .tbus_cpu_oe(bus_if.tbus_cpu_oe),
        .controller_bus_request_n(bus_if.controller_bus_request_n),
        .cpu_bus_release_n(bus_if.cpu_bus_release_n),
        .state_read_select_n(bus_if.state_read_select_n),
        .tag_write_strobe_n(bus_if.tag_write_strobe_n),
        .state_write_strobe_n(bus_if.state_write_strobe_n), .tram_oe_n(bus_if.tram_oe_n));

    // ----------------------------------------------------------------
    // clock, tag ram stand-in and hang guard
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'h0;
        forever #12.5 mclk = ~mclk;
    end

    // ram answers one clock after its enable, else a decoy pattern
    always @(posedge mclk) begin
        idx_q <= tram_index;
        set_q <= bus_if.set_select_lines;
        if (bus_if.tram_oe_n === 1'h0) tram_tag_in <= ram_val(idx_q, set_q);
        else tram_tag_in <= ~ram_val(idx_q, set_q);
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            finish_test();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [19:0] ram_val(input logic [10:0] i, input logic [1:0] s);
        return {s, i[6:0], i};
    endfunction

    function automatic logic [39:0] ret_word(input logic [10:0] i, input logic [1:0] s);
        logic [19:0] r;
        r = ram_val(i, s);
        return {r[17:0], r[19:18], 20'h00000};
    endfunction

    function automatic logic [31:0] mk_cmd(input logic [1:0] kind, input logic odd,
        input logic dirty, input logic [1:0] set, input logic [10:0] idx);
        return {15'h0000, dirty, odd, kind, set, idx};
    endfunction

    task automatic chk(input string name, input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'h0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        rd <= 1'h1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'h0;
        #1;
        chk(name, {8'h00, rdata}, {8'h00, exp});
    endtask

    // one read through both ends, checked clock by clock
    task automatic run_op(input logic [31:0] cmd, input int ret_cyc, input int set_cyc);
        logic [10:0] i;
        logic [1:0] s;
        logic [39:0] w;
        int seen;
        i = cmd[10:0];
        s = cmd[12:11];
        w = ret_word(i, s);
        seen = 0;
        wr_reg(trb_pkg::REG_CMD, cmd);
        for (int k = 1; k <= 12; k++) begin
            #1;
            if (k == 1) chk("func", {39'h0, bus_if.func == (cmd[15] ? 4'h6 : 4'h5)}, 40'h1);
            if (k == 1) chk("index", {29'h0, bus_if.tbus_cc[19:9]}, {29'h0, i});
            if (k == 2 && cmd[16]) chk("index 2", {29'h0, bus_if.tbus_cc[19:9]}, {29'h0, i});
            if (k == set_cyc) chk("set", {38'h0, bus_if.set_select_lines}, {38'h0, s});
            if (k == 3) chk("pins", {28'h0, tram_odd_sel, tram_index}, {28'h0, cmd[15], i});
            if (bus_if.tbus_cpu_oe === 1'h1) begin
                seen = k;
                chk("word", bus_if.tbus_cpu, w);
            end
            @(posedge mclk);
        end
        chk("ret clock", 40'(seen), 40'(ret_cyc));
        rd_chk("rd lo", trb_pkg::REG_RD_LO, w[31:0]);
        rd_chk("rd hi", trb_pkg::REG_RD_HI, {24'h000000, w[39:32]});
        rd_chk("status", trb_pkg::REG_STATUS, 32'h00000003);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic s_refuse_and_map();
        chk("reset bus", {36'h0, bus_if.tbus_cc_oe, bus_if.controller_bus_request_n,
            bus_if.cpu_bus_release_n, bus_if.tbus_cpu_oe}, 40'h A);
        rd_chk("ready", trb_pkg::REG_STATUS, 32'h00000001);
        wr_reg(trb_pkg::REG_CMD, mk_cmd(2'h3, 1'h0, 1'h0, 2'h0, 11'h010));
        #1;
        chk("no op", {36'h0, bus_if.func}, 40'h0);
        rd_chk("refused", trb_pkg::REG_STATUS, 32'h00000005);
        rd_chk("cleared", trb_pkg::REG_STATUS, 32'h00000001);
        rd_chk("unmapped", 8'hFC, 32'h00000000);
    endtask

    task automatic s_reads();
        run_op(mk_cmd(2'h0, 1'h1, 1'h0, 2'h3, 11'h7FF), 8, 3);
        run_op(mk_cmd(2'h0, 1'h0, 1'h0, 2'h2, 11'h001), 8, 3);
        run_op(mk_cmd(2'h1, 1'h1, 1'h0, 2'h1, 11'h2A5), 8, 3);
        run_op(mk_cmd(2'h1, 1'h0, 1'h1, 2'h2, 11'h55A), 9, 4);
    endtask

    task automatic s_back_to_back();
        logic [31:0] a;
        logic [31:0] b;
        int n;
        a = mk_cmd(2'h0, 1'h1, 1'h0, 2'h1, 11'h123);
        b = mk_cmd(2'h0, 1'h1, 1'h0, 2'h2, 11'h456);
        n = 0;
        @(posedge mclk);
        wr <= 1'h1;
        addr <= trb_pkg::REG_CMD;
        wdata <= a;
        @(posedge mclk);
        wdata <= b;
        @(posedge mclk);
        wr <= 1'h0;
        for (int k = 2; k <= 12; k++) begin
            #1;
            if (bus_if.tbus_cpu_oe === 1'h1) begin
                n++;
                chk("b2b word", bus_if.tbus_cpu,
                    n == 1 ? ret_word(a[10:0], a[12:11]) : ret_word(b[10:0], b[12:11]));
                chk("b2b clock", 40'(k), n == 1 ? 40'h7 : 40'h9);
            end
            @(posedge mclk);
        end
        chk("b2b count", 40'(n), 40'h2);
        rd_chk("b2b status", trb_pkg::REG_STATUS, 32'h00000003);
    endtask

    task automatic s_state_write();
        logic [31:0] wd;
        logic [39:0] e;
        wd = {14'h0000, 8'hE4, 4'hB, 4'hA, 1'h1, 1'h1};
        e = {1'h1, 1'h1, 4'hA, 4'hB, 8'hE4, 2'h0, 11'h3C5, 9'h000};
        wr_reg(trb_pkg::REG_WDATA, wd);
        rd_chk("wdata", trb_pkg::REG_WDATA, wd);
        wr_reg(trb_pkg::REG_CMD, mk_cmd(2'h2, 1'h0, 1'h0, 2'h1, 11'h3C5));
        #1;
        chk("wr word", {9'h0, bus_if.tbus_cc[39:9]}, {9'h0, e[39:9]});
        chk("wr func", {36'h0, bus_if.func}, {36'h0, trb_pkg::FN_STATE_WR});
        repeat (2) @(posedge mclk);
        #1;
        chk("ram write", {6'h0, tram_index, tram_tag_out, tram_tag_oe,
            bus_if.state_write_strobe_n, bus_if.tag_write_strobe_n},
            {6'h0, 11'h3C5, e[21:20], e[39:22], 3'h5});
        repeat (8) @(posedge mclk);
        rd_chk("wr status", trb_pkg::REG_STATUS, 32'h00000001);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'h0;
        wr = 1'h0;
        rd = 1'h0;
        addr = 8'h00;
        wdata = 32'h00000000;
        bad_count = 0;
        compares = 0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'h1;
        @(posedge mclk);
        #1;
        s_refuse_and_map();
        s_reads();
        s_back_to_back();
        s_state_write();
        finish_test();
    end
endmodule
